/* tosp_defs.svh */
`ifndef TOSP_DEFS_SVH
`define TOSP_DEFS_SVH

// ****************************************
// Register map, space B
// ****************************************
`define TOSP_ADDR_W        8
`define TOSP_OFF_OVER_HI   8'h30
`define TOSP_OFF_OVER_LO   8'h31
`define TOSP_OFF_UNDER_HI  8'h32
`define TOSP_OFF_UNDER_LO  8'h33
`define TOSP_OFF_CTRL      8'h3F
`define TOSP_OFF_STATUS    8'h3E
`define TOSP_RST_BYTE      8'h00

// ****************************************
// Field positions
// ****************************************
`define TOSP_MODE_MSB      7
`define TOSP_MODE_LSB      6
`define TOSP_CELL_HI_MSB   5
`define TOSP_CELLS         14
`define TOSP_CELL_IDX_W    4

// ****************************************
// Group mode field codes
// ****************************************
`define TOSP_SEL_DRIVER    2'h0
`define TOSP_SEL_MOD       2'h1
`define TOSP_SEL_STOP      2'h2
`define TOSP_SEL_RSVD      2'h3

`endif

/* tosp_pkg.sv */
package tosp_pkg;

  // Drive level chosen for the current carrier period
  typedef enum logic [1:0]
  {
    TOSP_DRV_NORMAL = 2'h0,
    TOSP_DRV_SUPPLY = 2'h1,
    TOSP_DRV_MODSUP = 2'h2,
    TOSP_DRV_STOP   = 2'h3
  } tosp_drive_type;

  // Sequencer phases
  typedef enum logic [1:0]
  {
    TOSP_ST_IDLE  = 2'h0,
    TOSP_ST_OVER  = 2'h1,
    TOSP_ST_UNDER = 2'h2
  } tosp_state_type;

  // Register port request
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tosp_req_type;

  // Drive command towards the driver stage
  typedef struct packed
  {
    logic           active;
    logic           under;
    tosp_drive_type level;
  } tosp_drv_type;

endpackage

/* tosp_cell_level.sv */
`timescale 1ns/1ps
`include "tosp_defs.svh"

// Maps one cell bit and its group mode to a drive level
module tosp_cell_level
(
  input  wire logic                    i_cell,
  input  wire logic [1:0]              i_mode,
  input  wire logic                    i_am_regulator_option,
  output tosp_pkg::tosp_drive_type     o_level
);

  // ****************************************
  // Level decode
  // ****************************************
  // Reserved mode code keeps normal drive, safest for the antenna
  wire tosp_pkg::tosp_drive_type mode_level =
    (i_mode == `TOSP_SEL_DRIVER) ? tosp_pkg::TOSP_DRV_SUPPLY :
    (i_mode == `TOSP_SEL_MOD)    ? tosp_pkg::TOSP_DRV_MODSUP :
    (i_mode == `TOSP_SEL_STOP)   ? tosp_pkg::TOSP_DRV_STOP   :
                                   tosp_pkg::TOSP_DRV_NORMAL;

  // Option on: the cell picks the supply; off: mode applies to set cells
  wire tosp_pkg::tosp_drive_type direct_level =
    i_cell ? tosp_pkg::TOSP_DRV_MODSUP : tosp_pkg::TOSP_DRV_SUPPLY;
  wire tosp_pkg::tosp_drive_type field_level =
    i_cell ? mode_level : tosp_pkg::TOSP_DRV_NORMAL;

  assign o_level = i_am_regulator_option ? direct_level : field_level;

endmodule

/* tosp_pattern.sv */
`timescale 1ns/1ps
`include "tosp_defs.svh"

// Overview of operation
// - Overshoot cells 7..0 live in bits 7..0 of register 31h, driven during modulation.
// - Undershoot cells follow modulation; 13..8 in 32h bits 5..0, 7..0 in 33h.
// - Undershoot mode 7:6: 00 driver supply, 01 modulation supply, 10 stop, 11 reserved.
// - Mode fields are ignored while the regulator option bit is one.
// - Option zero: each set cell drives at its own group's mode level.
// - Option one: cell zero uses driver supply, cell one modulation supply.
// - Overshoot mode in 30h bits 7:6, cells 13..8 in bits 5..0.
module tosp_pattern
#(
  parameter int CELLS = `TOSP_CELLS
)
(
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_sys_rst,
  input  wire logic [7:0]              i_reg_addr,
  input  wire logic [7:0]              i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output logic      [7:0]              o_reg_rdata,
  input  wire logic                    i_carrier_tick,
  input  wire logic                    i_mod_start,
  output tosp_pkg::tosp_drv_type       o_drive
);

  // ****************************************
  // Register port
  // ****************************************
  tosp_pkg::tosp_req_type req;
  assign req = '{wr: i_reg_wr, rd: i_reg_rd, addr: i_reg_addr, wdata: i_reg_wdata};

  logic [7:0] over_hi_q;
  logic [7:0] over_lo_q;
  logic [7:0] under_hi_q;
  logic [7:0] under_lo_q;
  logic       ctrl_q;
  logic [7:0] rdata_q;

  wire hit_over_hi  = req.addr == `TOSP_OFF_OVER_HI;
  wire hit_over_lo  = req.addr == `TOSP_OFF_OVER_LO;
  wire hit_under_hi = req.addr == `TOSP_OFF_UNDER_HI;
  wire hit_under_lo = req.addr == `TOSP_OFF_UNDER_LO;
  wire hit_ctrl     = req.addr == `TOSP_OFF_CTRL;
  wire hit_status   = req.addr == `TOSP_OFF_STATUS;

  // ****************************************
  // Helpers
  // ****************************************
  // Joins a group's two registers into one cell vector, bit n is cell n
  function automatic logic [13:0] group_cells
  (
    input logic [7:0] hi_byte,
    input logic [7:0] lo_byte
  );
    return {hi_byte[`TOSP_CELL_HI_MSB:0], lo_byte};
  endfunction

  // Mode field of a group's first register
  function automatic logic [1:0] group_mode
  (
    input logic [7:0] hi_byte
  );
    return hi_byte[`TOSP_MODE_MSB:`TOSP_MODE_LSB];
  endfunction

  // Next cell index; wraps to cell 0 after the last cell of a group
  function automatic logic [`TOSP_CELL_IDX_W-1:0] step_idx
  (
    input logic [`TOSP_CELL_IDX_W-1:0] idx,
    input logic                        wrap
  );
    return wrap ? '0 : idx + 1'b1;
  endfunction

  // Register writes; a write to status or to a free address is dropped
  // Nothing stalls, so a write lands at the edge of its own strobe
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      over_hi_q  <= `TOSP_RST_BYTE;
      over_lo_q  <= `TOSP_RST_BYTE;
      under_hi_q <= `TOSP_RST_BYTE;
      under_lo_q <= `TOSP_RST_BYTE;
      ctrl_q     <= 1'b0;
    end
    else if (req.wr)
    begin
      if (hit_over_hi)  over_hi_q  <= req.wdata;
      if (hit_over_lo)  over_lo_q  <= req.wdata;
      if (hit_under_hi) under_hi_q <= req.wdata;
      if (hit_under_lo) under_lo_q <= req.wdata;
      if (hit_ctrl)     ctrl_q     <= req.wdata[0];
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  tosp_pkg::tosp_state_type    state_q;
  tosp_pkg::tosp_state_type    state_d;
  logic [`TOSP_CELL_IDX_W-1:0] idx_q;
  logic [`TOSP_CELL_IDX_W-1:0] idx_d;

  // Index width covers up to sixteen cells; a larger group needs a wider index
  wire last_cell = idx_q == (`TOSP_CELL_IDX_W)'(CELLS - 1);

  // Cell vectors, bit n is cell n
  // Fields are read live: a write during a sequence shows from the next clock on
  // Software should rewrite patterns only while the sequencer is idle
  wire [13:0] over_cells  = group_cells(over_hi_q, over_lo_q);
  wire [13:0] under_cells = group_cells(under_hi_q, under_lo_q);
  wire [1:0]  over_mode   = group_mode(over_hi_q);
  wire [1:0]  under_mode  = group_mode(under_hi_q);

  // A new modulation start restarts the overshoot group at cell 0
  // Start wins over a tick in the same cycle, so cell 0 is never skipped
  always_comb
  begin
    state_d = state_q;
    idx_d   = idx_q;
    if (i_mod_start)
    begin
      state_d = tosp_pkg::TOSP_ST_OVER;
      idx_d   = '0;
    end
    else if (i_carrier_tick)
    begin
      case (state_q)
        tosp_pkg::TOSP_ST_OVER:
        begin
          idx_d   = step_idx(idx_q, last_cell);
          state_d = last_cell ? tosp_pkg::TOSP_ST_UNDER : state_q;
        end
        tosp_pkg::TOSP_ST_UNDER:
        begin
          idx_d   = step_idx(idx_q, last_cell);
          state_d = last_cell ? tosp_pkg::TOSP_ST_IDLE : state_q;
        end
        default:
        begin
          state_d = tosp_pkg::TOSP_ST_IDLE;
          idx_d   = '0;
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_q <= tosp_pkg::TOSP_ST_IDLE;
      idx_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      idx_q   <= idx_d;
    end
  end

  // ****************************************
  // Drive level
  // ****************************************
  wire        in_under = state_q == tosp_pkg::TOSP_ST_UNDER;
  wire        cell_bit = in_under ? under_cells[idx_q] : over_cells[idx_q];
  wire [1:0]  cur_mode = in_under ? under_mode : over_mode;
  tosp_pkg::tosp_drive_type cell_level;

  // One level table serves both groups, so their decode cannot drift apart
  tosp_cell_level u_level
  (
    .i_cell                (cell_bit),
    .i_mode                (cur_mode),
    .i_am_regulator_option (ctrl_q),
    .o_level               (cell_level)
  );

  // Registered drive output; idle keeps normal drive
  // The flop keeps decode glitches away from the driver stage
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_drive <= '{active: 1'b0, under: 1'b0, level: tosp_pkg::TOSP_DRV_NORMAL};
    else if (state_q == tosp_pkg::TOSP_ST_IDLE)
      o_drive <= '{active: 1'b0, under: 1'b0, level: tosp_pkg::TOSP_DRV_NORMAL};
    else
      o_drive <= '{active: 1'b1, under: in_under, level: cell_level};
  end

  // ****************************************
  // Read path
  // ****************************************
  // Status shows phase and cell index so software can watch the sequence
  // Reads have no side effects, so status may be polled freely
  wire [7:0] status_byte = {2'h0, state_q, idx_q};
  wire [7:0] rd_mux =
    hit_over_hi  ? over_hi_q  :
    hit_over_lo  ? over_lo_q  :
    hit_under_hi ? under_hi_q :
    hit_under_lo ? under_lo_q :
    hit_ctrl     ? {7'h00, ctrl_q} :
    hit_status   ? status_byte : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= req.rd ? rd_mux : 8'h00;
  end

  assign o_reg_rdata = rdata_q;

endmodule

/* tosp_pattern_asserts.sv */
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module tosp_pattern_chk
(
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        i_carrier_tick,
  input wire logic        i_mod_start,
  input tosp_pkg::tosp_drv_type o_drive
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Address decode for the unmapped check
  wire map_w = i_reg_addr inside {8'h30, 8'h31, 8'h32, 8'h33, 8'h3E, 8'h3F};
  a_rd_idle: assert property (
    !$past(i_reg_rd) |-> o_reg_rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_rd: assert property (
    i_reg_rd && !map_w |=> o_reg_rdata == 8'h00) else $error("unmapped read");
  a_over_hi_back: assert property (
    i_reg_wr && i_reg_addr == 8'h30 ##1 i_reg_rd && i_reg_addr == 8'h30
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("30 readback");
  a_over_lo_back: assert property (
    i_reg_wr && i_reg_addr == 8'h31 ##1 i_reg_rd && i_reg_addr == 8'h31
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("31 readback");
  a_under_hi_back: assert property (
    i_reg_wr && i_reg_addr == 8'h32 ##1 i_reg_rd && i_reg_addr == 8'h32
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("32 readback");
  a_under_lo_back: assert property (
    i_reg_wr && i_reg_addr == 8'h33 ##1 i_reg_rd && i_reg_addr == 8'h33
    |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("33 readback");
  a_start_over: assert property (
    i_mod_start |-> ##2 !o_drive.under) else $error("start not overshoot");
  // Drive only moves two edges after its causes
  a_drive_cause: assert property (
    $changed(o_drive) |-> $past(i_carrier_tick, 2) || $past(i_mod_start, 2)
    || $past(i_reg_wr, 2)) else $error("drive moved");
  a_under_rise: assert property (
    $rose(o_drive.under) |-> $past(i_carrier_tick, 2)) else $error("under early");
  a_reset_drive: assert property (
    $fell(i_sys_rst) |-> o_drive == '0) else $error("drive after reset");
endmodule

bind tosp_pattern tosp_pattern_chk chk_u (.i_clk_sys, .i_sys_rst, .i_reg_addr,
  .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_carrier_tick,
  .i_mod_start, .o_drive);

/* tosp_carrier_model.sv */
`timescale 1ns/1ps
// Carrier divider; start held until a period boundary
module tosp_carrier_model
#(
  parameter int PERIOD = 4
)
(
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  input  wire logic i_start_req,
  output logic      o_carrier_tick,
  output logic      o_mod_start
);
  logic [7:0] cnt_q;
  logic       pend_q;
  // Start lands PERIOD-1 cycles before a tick, so each cell settles first
  assign o_carrier_tick = (cnt_q == 8'(PERIOD - 1));
  assign o_mod_start    = pend_q && (cnt_q == 8'h00);
  // Free-running count and pending start
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cnt_q  <= 8'h00;
      pend_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= o_carrier_tick ? 8'h00 : cnt_q + 8'h01;
      pend_q <= !o_mod_start && (pend_q || i_start_req);
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic                   i_clk_sys, i_sys_rst, i_reg_wr, i_reg_rd, start_req;
  logic                   tick, mstart;
  logic [7:0]             i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [1:0]             om, um;
  tosp_pkg::tosp_drv_type o_drive;
  int                     failures, total_checks, cyc, m;
  logic [7:0]             rmap [6] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h3E, 8'h3F};

  tosp_pattern dut_u (.i_clk_sys, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .i_carrier_tick(tick), .i_mod_start(mstart), .o_drive);
  tosp_carrier_model car_u (.i_clk_sys, .i_sys_rst, .i_start_req(start_req),
    .o_carrier_tick(tick), .o_mod_start(mstart));

  // Clock and hang guard
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end

  task test_done;
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write strobe stays up until the read that always follows
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1; i_reg_rd <= 1'b0; i_reg_addr <= a; i_reg_wdata <= d;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0; i_reg_rd <= 1'b1; i_reg_addr <= a;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(negedge i_clk_sys);
    chk(o_reg_rdata, e);
  endtask
  task wrrd(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    rd(a, d);
  endtask
  // Expected level of one cell
  function automatic logic [1:0] lvl(input logic c, input logic opt, input logic [1:0] md);
    if (opt) return c ? 2'h2 : 2'h1;
    if (!c || md == 2'h3) return 2'h0;
    return md + 2'h1;
  endfunction
  // One whole modulation sequence, checked just before each tick
  task run(input logic opt);
    logic [27:0] cells;
    int          n;
    cells = {14'h1CC3, 14'h255A};
    @(posedge i_clk_sys);
    start_req <= 1'b1;
    @(posedge i_clk_sys);
    start_req <= 1'b0;
    n = 0;
    do begin @(negedge i_clk_sys); n++; end while (!mstart && n < 20);
    for (int i = 0; i < 28; i++)
    begin
      n = 0;
      do begin @(negedge i_clk_sys); n++; end while (!tick && n < 20);
      chk({4'h0, o_drive.active, o_drive.under, o_drive.level},
          {4'h0, 1'b1, i > 13, lvl(cells[i], opt, i > 13 ? um : om)});
    end
    repeat (3) @(negedge i_clk_sys);
    chk({4'h0, o_drive}, 8'h00);
  endtask

  // Main sequence
  initial
  begin
    i_sys_rst = 1'b1; i_reg_wr = 1'b0; i_reg_rd = 1'b0; start_req = 1'b0;
    i_reg_addr = 8'h00; i_reg_wdata = 8'h00;
    repeat (2) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    foreach (rmap[k]) rd(rmap[k], 8'h00);
    wr(8'h40, 8'h5A);
    rd(8'h40, 8'h00);
    for (m = 0; m < 5; m++)
    begin
      om = (m == 4) ? 2'h2 : m[1:0];
      um = ~om;
      wrrd(8'h30, {om, 6'h25});
      wrrd(8'h31, 8'h5A);
      wrrd(8'h32, {um, 6'h1C});
      wrrd(8'h33, 8'hC3);
      wrrd(8'h3F, {7'h00, m == 4});
      run(m == 4);
    end
    test_done();
  end
endmodule
